// [ssdl_core.sv]
// Serial command decoder, output control and diagnosis answer of the 16-channel switch
`timescale 1ns/1ps
// Overview of operation
// - Upper nibble all low: diagnosis only, data ignored, outputs unchanged.
// - Diagnosis-only lasts one frame unless the next frame repeats it.
// - Read-back returns the eight sampled parallel inputs as the first eight bits.
// - Read-back second byte: one fault bit per channel, high means no fault.
// - Echo connects serial input to serial output for the next frame only.
// - Echo processes nothing; afterwards channels and mode are kept and the next answer reads zero.
// - OR command on low group: channels 1-4 on if parallel or serial bit active.
// - OR command on high group combines channels 9-12 inputs with serial bits.
// - After reset the combining operation is OR.
// - Combining operation is latched until the opposite operation is commanded.
// - AND command on low group ANDs channels 1-4 inputs with serial bits.
// - AND command on high group ANDs channels 9-12 inputs with serial bits.
// - In AND mode channels 1-4 and 9-12 are on only when both requests are on.
// - Unknown command only raises the reject flag and the next frame shifts out zeros.
// - Full diagnosis codes: HH normal, HL limit, LH open load, LL short.
// - Diagnosis latches of the previously named group clear at falling chip select when that frame shifts out full diagnosis or read-back.
// - Control and diagnosis-only commands answer full diagnosis of that group next frame.
// - Frame content is taken only at the rising chip select edge.
// - Control bits 0-3 all low select channels 1-8, all high 9-16.
// - In control commands a high data bit requests its channel on.
module ssdl_core
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic [ssdl_pkg::PAR_INPUTS-1:0] par_in,
  input wire logic [2*ssdl_pkg::CHANNELS-1:0] diag_in,
  output logic so_out,
  output logic so_oe_n_out,
  output logic [ssdl_pkg::CHANNELS-1:0] chan_on_out,
  output logic and_mode_out,
  output logic cmd_reject_out
);

  ssdl_link_if link ();

  logic [ssdl_pkg::FRAME_BITS-1:0] in_sr_r;
  logic [ssdl_pkg::FRAME_BITS-1:0] out_sr_r;
  logic [4:0] bit_cnt_r;
  logic [ssdl_pkg::CHANNELS-1:0] serial_data_r;
  logic [ssdl_pkg::CHANNELS-1:0] serial_data_nxt;
  logic and_mode_r;
  logic and_mode_nxt;
  ssdl_pkg::ssdl_resp_t resp_kind_r;
  ssdl_pkg::ssdl_resp_t resp_kind_nxt;
  logic resp_high_r;
  logic resp_high_nxt;
  logic echo_active_r;
  logic so_r;
  logic so_oe_n_r;
  logic [ssdl_pkg::CHANNELS-1:0] chan_on_r;
  logic cmd_reject_r;
  logic cmd_reject_nxt;
  logic clr_low_r;
  logic clr_high_r;
  logic [2*ssdl_pkg::CHANNELS-1:0] diag_lat;

  ssdl_sampler u_sampler
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .par_in(par_in),
    .link(link.sampler)
  );

  ssdl_diag_latch u_diag
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .diag_in(diag_in),
    .clr_low_in(clr_low_r),
    .clr_high_in(clr_high_r),
    .latch_out(diag_lat)
  );

  // Frame decode
  wire logic [3:0] op_code;
  wire logic [3:0] grp_code;
  wire logic [7:0] data_byte;
  wire logic frame_full;
  wire logic grp_ok;
  wire logic grp_high;
  wire logic op_diag;
  wire logic op_read;
  wire logic op_echo;
  wire logic op_or;
  wire logic op_and;
  wire logic cmd_ok;
  wire logic cmd_ctrl;

  assign op_code = in_sr_r[ssdl_pkg::OP_MSB:ssdl_pkg::OP_LSB];
  assign grp_code = in_sr_r[ssdl_pkg::GRP_MSB:ssdl_pkg::GRP_LSB];
  assign data_byte = in_sr_r[ssdl_pkg::DATA_MSB:0];
  assign frame_full = (bit_cnt_r == 5'(ssdl_pkg::FRAME_BITS));
  assign grp_ok = (grp_code == ssdl_pkg::GRP_LOW) || (grp_code == ssdl_pkg::GRP_HIGH);
  assign grp_high = (grp_code == ssdl_pkg::GRP_HIGH);
  assign op_diag = (op_code == ssdl_pkg::OP_DIAG);
  assign op_read = (op_code == ssdl_pkg::OP_READ);
  assign op_echo = (op_code == ssdl_pkg::OP_ECHO);
  assign op_or = (op_code == ssdl_pkg::OP_OR);
  assign op_and = (op_code == ssdl_pkg::OP_AND);
  // A frame of the wrong length is handled like an unknown command
  assign cmd_ok = frame_full && grp_ok && (op_diag || op_read || op_echo || op_or || op_and);
  assign cmd_ctrl = cmd_ok && (op_or || op_and);

  // Commit at the end of a frame; the frame carried in during an echo is never executed
  always_comb
  begin
    serial_data_nxt = serial_data_r;
    and_mode_nxt = and_mode_r;
    resp_kind_nxt = resp_kind_r;
    resp_high_nxt = resp_high_r;
    cmd_reject_nxt = cmd_reject_r;
    if (link.cs_rise)
    begin
      cmd_reject_nxt = 1'b0;
      if (echo_active_r)
      begin
        resp_kind_nxt = ssdl_pkg::SSDL_RESP_ZERO;
      end
      else if (!cmd_ok)
      begin
        resp_kind_nxt = ssdl_pkg::SSDL_RESP_ZERO;
        cmd_reject_nxt = 1'b1;
      end
      else
      begin
        resp_high_nxt = grp_high;
        if (cmd_ctrl)
        begin
          // Only the addressed group takes the data byte
          if (grp_high)
            serial_data_nxt[ssdl_pkg::CHANNELS-1:ssdl_pkg::GROUP_CH] = data_byte;
          else
            serial_data_nxt[ssdl_pkg::GROUP_CH-1:0] = data_byte;
          and_mode_nxt = op_and;
          resp_kind_nxt = ssdl_pkg::SSDL_RESP_FULL;
        end
        else if (op_diag)
          resp_kind_nxt = ssdl_pkg::SSDL_RESP_FULL;
        else if (op_read)
          resp_kind_nxt = ssdl_pkg::SSDL_RESP_READ;
        else
          resp_kind_nxt = ssdl_pkg::SSDL_RESP_ECHO;
      end
    end
  end

  // Answer built at the falling chip select edge
  wire logic [2*ssdl_pkg::GROUP_CH-1:0] grp_diag;
  wire logic [ssdl_pkg::GROUP_CH-1:0] grp_fault_ok;
  logic [ssdl_pkg::FRAME_BITS-1:0] resp_word;

  assign grp_diag = resp_high_r ? diag_lat[2*ssdl_pkg::CHANNELS-1:2*ssdl_pkg::GROUP_CH]
                                : diag_lat[2*ssdl_pkg::GROUP_CH-1:0];

  genvar g;
  generate
    for (g = 0; g < ssdl_pkg::GROUP_CH; g++)
    begin : g_fault
      assign grp_fault_ok[g] = (grp_diag[2*g +: 2] == ssdl_pkg::DIAG_NORMAL);
    end
  endgenerate

  always_comb
  begin
    unique case (resp_kind_r)
      ssdl_pkg::SSDL_RESP_FULL: resp_word = grp_diag;
      ssdl_pkg::SSDL_RESP_READ: resp_word = {link.par, grp_fault_ok};
      ssdl_pkg::SSDL_RESP_ECHO: resp_word = ssdl_pkg::RST_RESPONSE;
      ssdl_pkg::SSDL_RESP_ZERO: resp_word = ssdl_pkg::RST_RESPONSE;
      default: resp_word = ssdl_pkg::RST_RESPONSE;
    endcase
  end

  // Output stage combine; parallel inputs reach channels 1-4 and 9-12 only
  logic [ssdl_pkg::CHANNELS-1:0] chan_on_nxt;
  wire logic [ssdl_pkg::CHANNELS-1:0] par_map;
  wire logic [ssdl_pkg::CHANNELS-1:0] par_capable;

  assign par_map = {4'h0, link.par[7:4], 4'h0, link.par[3:0]};
  assign par_capable = 16'h0f0f;

  always_comb
  begin
    chan_on_nxt = serial_data_r;
    for (int i = 0; i < ssdl_pkg::CHANNELS; i++)
    begin
      if (par_capable[i])
      begin
        if (and_mode_r)
          chan_on_nxt[i] = par_map[i] & serial_data_r[i];
        else
          chan_on_nxt[i] = par_map[i] | serial_data_r[i];
      end
    end
  end

  // Command state and output control
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      serial_data_r <= ssdl_pkg::RST_SERIAL_DATA;
      and_mode_r <= ssdl_pkg::RST_AND_MODE;
      resp_kind_r <= ssdl_pkg::SSDL_RESP_ZERO;
      resp_high_r <= 1'b0;
      cmd_reject_r <= 1'b0;
      chan_on_r <= ssdl_pkg::RST_SERIAL_DATA;
    end
    else
    begin
      serial_data_r <= serial_data_nxt;
      and_mode_r <= and_mode_nxt;
      resp_kind_r <= resp_kind_nxt;
      resp_high_r <= resp_high_nxt;
      cmd_reject_r <= cmd_reject_nxt;
      chan_on_r <= chan_on_nxt;
    end
  end

  // Input shifting on falling clock edges
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      in_sr_r <= ssdl_pkg::RST_RESPONSE;
      bit_cnt_r <= ssdl_pkg::RST_BIT_CNT;
    end
    else if (link.cs_fall)
    begin
      in_sr_r <= ssdl_pkg::RST_RESPONSE;
      bit_cnt_r <= ssdl_pkg::RST_BIT_CNT;
    end
    else if (link.sclk_fall)
    begin
      in_sr_r <= {in_sr_r[ssdl_pkg::FRAME_BITS-2:0], link.si};
      // Saturates so an overlong frame never wraps back to a valid length
      if (bit_cnt_r != 5'h1f)
        bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // Output shifting: load at frame start, advance after each falling edge, show on rising edge
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_sr_r <= ssdl_pkg::RST_RESPONSE;
      so_r <= 1'b0;
      echo_active_r <= 1'b0;
    end
    else if (link.cs_fall)
    begin
      out_sr_r <= resp_word;
      so_r <= resp_word[ssdl_pkg::FRAME_BITS-1];
      echo_active_r <= (resp_kind_r == ssdl_pkg::SSDL_RESP_ECHO);
    end
    else if (link.cs_rise)
      echo_active_r <= 1'b0;
    else if (link.sclk_fall)
      out_sr_r <= {out_sr_r[ssdl_pkg::FRAME_BITS-2:0], 1'b0};
    else if (link.sclk_rise)
    begin
      if (echo_active_r)
        so_r <= in_sr_r[0];
      else
        so_r <= out_sr_r[ssdl_pkg::FRAME_BITS-1];
    end
  end

  // Diagnosis latch clear pulses and pin enable
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      clr_low_r <= 1'b0;
      clr_high_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end
    else
    begin
      // Only a frame that really carried diagnosis clears; the answer samples the latch first
      clr_low_r <= link.cs_fall && !resp_high_r &&
                   ((resp_kind_r == ssdl_pkg::SSDL_RESP_FULL) || (resp_kind_r == ssdl_pkg::SSDL_RESP_READ));
      clr_high_r <= link.cs_fall && resp_high_r &&
                    ((resp_kind_r == ssdl_pkg::SSDL_RESP_FULL) || (resp_kind_r == ssdl_pkg::SSDL_RESP_READ));
      so_oe_n_r <= !link.cs_low;
    end
  end

  assign so_out = so_r;
  assign so_oe_n_out = so_oe_n_r;
  assign chan_on_out = chan_on_r;
  assign and_mode_out = and_mode_r;
  assign cmd_reject_out = cmd_reject_r;

endmodule

// [ssdl_pkg.sv]
// Shared constants and types of the switch serial command and diagnosis logic
package ssdl_pkg;

  localparam int unsigned CHANNELS = 16;
  localparam int unsigned GROUP_CH = 8;
  localparam int unsigned PAR_INPUTS = 8;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned SYNC_STAGES = 2;

  // Field positions within the received 16-bit frame
  localparam int unsigned OP_MSB = 15;
  localparam int unsigned OP_LSB = 12;
  localparam int unsigned GRP_MSB = 11;
  localparam int unsigned GRP_LSB = 8;
  localparam int unsigned DATA_MSB = 7;

  // Upper control nibble codes
  localparam logic [3:0] OP_DIAG = 4'h0;
  localparam logic [3:0] OP_READ = 4'hc;
  localparam logic [3:0] OP_ECHO = 4'ha;
  localparam logic [3:0] OP_OR = 4'h3;
  localparam logic [3:0] OP_AND = 4'hf;

  // Lower control nibble codes
  localparam logic [3:0] GRP_LOW = 4'h0;
  localparam logic [3:0] GRP_HIGH = 4'hf;

  // Values after reset
  localparam logic [15:0] RST_SERIAL_DATA = 16'h0000;
  localparam logic RST_AND_MODE = 1'b0;
  localparam logic [15:0] RST_RESPONSE = 16'h0000;
  localparam logic [31:0] RST_DIAG = 32'hffff_ffff;
  localparam logic [4:0] RST_BIT_CNT = 5'h00;

  // Two bits per channel: normal, current limit, open load, short to ground
  localparam logic [1:0] DIAG_NORMAL = 2'h3;
  localparam logic [1:0] DIAG_LIMIT = 2'h2;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_SHORT_GND = 2'h0;

  // What the next frame shifts out
  typedef enum logic [3:0]
  {
    SSDL_RESP_ZERO = 4'b0001,
    SSDL_RESP_FULL = 4'b0010,
    SSDL_RESP_READ = 4'b0100,
    SSDL_RESP_ECHO = 4'b1000
  } ssdl_resp_t;

endpackage

// [ssdl_link_if.sv]
// Synchronised serial link signals passed from the sampler to the command core
`timescale 1ns/1ps
interface ssdl_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic si;
  logic [ssdl_pkg::PAR_INPUTS-1:0] par;

  modport sampler
  (
    output sclk_rise,
    output sclk_fall,
    output cs_fall,
    output cs_rise,
    output cs_low,
    output si,
    output par
  );

  modport core
  (
    input sclk_rise,
    input sclk_fall,
    input cs_fall,
    input cs_rise,
    input cs_low,
    input si,
    input par
  );
endinterface

// [ssdl_sampler.sv]
// Two-flop synchronisers for the serial pins and parallel inputs, edge finders for serial clock and chip select
`timescale 1ns/1ps
module ssdl_sampler
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic [ssdl_pkg::PAR_INPUTS-1:0] par_in,
  ssdl_link_if.sampler link
);

  localparam int unsigned W = 3 + ssdl_pkg::PAR_INPUTS;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic sclk_d_r;
  logic cs_n_d_r;
  wire logic sclk_s;
  wire logic cs_n_s;

  // Idle chip select and clock levels avoid false edges out of reset
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= {1'b0, 1'b1, {(W-2){1'b0}}};
      sync_r <= {1'b0, 1'b1, {(W-2){1'b0}}};
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      meta_r <= {sclk_in, cs_n_in, si_in, par_in};
      sync_r <= meta_r;
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  assign sclk_s = sync_r[W-1];
  assign cs_n_s = sync_r[W-2];
  assign link.si = sync_r[W-3];
  assign link.par = sync_r[ssdl_pkg::PAR_INPUTS-1:0];
  assign link.cs_low = !cs_n_s;
  assign link.sclk_rise = sclk_s && !sclk_d_r && !cs_n_s;
  assign link.sclk_fall = !sclk_s && sclk_d_r && !cs_n_s;
  assign link.cs_fall = !cs_n_s && cs_n_d_r;
  assign link.cs_rise = cs_n_s && !cs_n_d_r;

endmodule

// [ssdl_diag_latch.sv]
// Sticky two-bit fault latches per channel, cleared per group after a read
`timescale 1ns/1ps
module ssdl_diag_latch
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [2*ssdl_pkg::CHANNELS-1:0] diag_in,
  input wire logic clr_low_in,
  input wire logic clr_high_in,
  output logic [2*ssdl_pkg::CHANNELS-1:0] latch_out
);

  logic [2*ssdl_pkg::CHANNELS-1:0] meta_r;
  logic [2*ssdl_pkg::CHANNELS-1:0] live_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= ssdl_pkg::RST_DIAG;
      live_r <= ssdl_pkg::RST_DIAG;
    end
    else
    begin
      meta_r <= diag_in;
      live_r <= meta_r;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < ssdl_pkg::CHANNELS; ch++)
    begin : g_ch
      wire logic clr;
      assign clr = (ch < ssdl_pkg::GROUP_CH) ? clr_low_in : clr_high_in;
      // A fault pulls a code bit low and keeps it low; a clear reloads the live code so a fault present now survives
      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
          latch_out[2*ch +: 2] <= ssdl_pkg::DIAG_NORMAL;
        else if (clr)
          latch_out[2*ch +: 2] <= live_r[2*ch +: 2];
        else
          latch_out[2*ch +: 2] <= latch_out[2*ch +: 2] & live_r[2*ch +: 2];
      end
    end
  endgenerate

endmodule

// [ssdl_core_asserts.sv]
// Port-level checker of the serial command and diagnosis core
`timescale 1ns/1ps
module ssdl_core_asserts
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic [7:0] par_in,
  input wire logic [31:0] diag_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  input wire logic [15:0] chan_on_out,
  input wire logic and_mode_out,
  input wire logic cmd_reject_out
);
  logic cs_q_r;
  logic [4:0] since_r;
  logic [4:0] since_nxt;
  // Saturates so that state changes long after a frame end are caught
  assign since_nxt = (cs_n_in && !cs_q_r) ? 5'h00 : since_r + {4'h0, since_r != 5'h1f};

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cs_q_r <= 1'b1;
      since_r <= 5'h1f;
    end
    else
    begin
      cs_q_r <= cs_n_in;
      since_r <= since_nxt;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_oe_on_select: assert property ($fell(cs_n_in) |-> ##[1:5] !so_oe_n_out)
    else $error("serial output enable late after select");
  chk_oe_on_release: assert property ($rose(cs_n_in) |-> ##[1:5] so_oe_n_out)
    else $error("serial output enable late after deselect");
  chk_oe_idle_high: assert property (cs_n_in [*6] |-> so_oe_n_out)
    else $error("serial output enabled outside a frame");
  chk_so_bit_hold: assert property (!cs_n_in && $fell(sclk_in) |-> $stable(so_out) [*3])
    else $error("serial output moved after a falling clock");
  chk_chan_at_end: assert property ($changed(chan_on_out & 16'hf0f0) |-> since_r inside {[1:8]})
    else $error("serial channel changed away from frame end");
  chk_mode_at_end: assert property ($changed(and_mode_out) |-> since_r inside {[1:8]})
    else $error("combine mode changed away from frame end");
  chk_reject_at_end: assert property ($changed(cmd_reject_out) |-> since_r inside {[1:8]})
    else $error("reject flag changed away from frame end");
  chk_or_after_reset: assert property ($rose(reset_n_in) |-> !and_mode_out)
    else $error("combine mode not OR after reset");
  chk_or_low_par: assert property ((!and_mode_out && par_in[0]) [*6] |-> chan_on_out[0])
    else $error("parallel input alone did not switch channel 1");
  chk_or_high_par: assert property ((!and_mode_out && par_in[4]) [*6] |-> chan_on_out[8])
    else $error("parallel input alone did not switch channel 9");
  chk_and_par_off: assert property ((and_mode_out && !par_in[0]) [*6] |-> !chan_on_out[0])
    else $error("channel 1 on in AND mode with parallel input off");

  cover property ($rose(and_mode_out));
  cover property ($rose(cmd_reject_out));
  cover property ($fell(cs_n_in) ##[1:5] !so_oe_n_out);
endmodule

bind ssdl_core ssdl_core_asserts u_chk (.clk_in, .reset_n_in, .sclk_in, .cs_n_in, .si_in, .par_in,
  .diag_in, .so_out, .so_oe_n_out, .chan_on_out, .and_mode_out, .cmd_reject_out);

// [ssdl_master.sv]
// Behavioural serial master that frames commands and collects answers
`timescale 1ns/1ps
module ssdl_master
#(
  parameter int HALF = 4
)
(
  input wire logic clk_in,
  input wire logic so_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Each answer bit is taken just before the falling clock, once the rising one has moved it out
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    wait_clk(HALF);
    for (int i = 15; i >= 0; i--)
    begin
      sclk_out = 1'b1;
      si_out = tx[i];
      wait_clk(HALF);
      rx[i] = so_in;
      sclk_out = 1'b0;
      wait_clk(HALF);
    end
    cs_n_out = 1'b1;
    // A released data line must not keep showing the last bit
    si_out = ~si_out;
    wait_clk(2 * HALF);
  endtask
endmodule

// [tb.sv]
// Self-checking bench of the serial command core driven by a behavioural master
`timescale 1ns/1ps
module tb;
  logic clk_in;
  logic reset_n_in;
  logic sclk_in;
  logic cs_n_in;
  logic si_in;
  logic [7:0] par_in;
  logic [31:0] diag_in;
  logic so_out;
  logic so_oe_n_out;
  logic [15:0] chan_on_out;
  logic and_mode_out;
  logic cmd_reject_out;
  logic [15:0] rx;
  int n_mismatch;
  int cmp_count;

  ssdl_core uut (.clk_in, .reset_n_in, .sclk_in, .cs_n_in, .si_in, .par_in, .diag_in, .so_out,
    .so_oe_n_out, .chan_on_out, .and_mode_out, .cmd_reject_out);
  ssdl_master m (.clk_in, .so_in(so_out), .sclk_out(sclk_in), .cs_n_out(cs_n_in), .si_out(si_in));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic outs(input string what, input logic [15:0] ch, input logic md);
    cmp({what, " channels"}, ch, chan_on_out);
    cmp({what, " mode"}, {15'h0, md}, {15'h0, and_mode_out});
  endtask

  task automatic frame(input logic [15:0] tx);
    m.xfer(tx, rx);
  endtask

  function automatic logic [7:0] ok_bits(input logic [15:0] d);
    for (int k = 0; k < 8; k++)
      ok_bits[k] = (d[2*k+1 -: 2] === 2'h3);
  endfunction

  task automatic t_reset();
    cmp("reject at reset", 16'h0000, {15'h0, cmd_reject_out});
    cmp("idle enable", 16'h0001, {15'h0, so_oe_n_out});
    outs("reset", 16'h0000, 1'b0);
    par_in = 8'h11;
    repeat (8) @(negedge clk_in);
    outs("parallel only", 16'h0101, 1'b0);
  endtask

  task automatic t_or();
    frame(16'h3091);
    outs("or low", 16'h0191, 1'b0);
    frame(16'h3fa8);
    outs("or high", 16'ha991, 1'b0);
    cmp("or answer", diag_in[15:0], rx);
  endtask

  task automatic t_diag();
    frame(16'h00ff);
    outs("diag only", 16'ha991, 1'b0);
    cmp("high answer", diag_in[31:16], rx);
    frame(16'h0f00);
    cmp("low answer", diag_in[15:0], rx);
  endtask

  task automatic t_read();
    par_in = 8'h6c;
    frame(16'hc000);
    cmp("diag repeat", diag_in[31:16], rx);
    frame(16'hcf00);
    cmp("read back", {8'h6c, ok_bits(diag_in[15:0])}, rx);
    frame(16'h0000);
    cmp("read back high", {8'h6c, ok_bits(diag_in[31:16])}, rx);
    par_in = 8'h11;
    repeat (8) @(negedge clk_in);
    outs("after read", 16'ha991, 1'b0);
  endtask

  task automatic t_and();
    frame(16'hf031);
    outs("and low", 16'ha031, 1'b1);
    frame(16'hff09);
    outs("and high", 16'h0131, 1'b1);
    par_in = 8'h10;
    repeat (8) @(negedge clk_in);
    outs("and par off", 16'h0130, 1'b1);
    par_in = 8'h11;
    repeat (8) @(negedge clk_in);
    frame(16'h000f);
    outs("and kept", 16'h0131, 1'b1);
    frame(16'h3f00);
    outs("or again", 16'h0131, 1'b0);
  endtask

  task automatic t_reject();
    frame(16'h70f0);
    cmp("reject flag", 16'h0001, {15'h0, cmd_reject_out});
    outs("rejected", 16'h0131, 1'b0);
    frame(16'h0000);
    cmp("reject answer", 16'h0000, rx);
    cmp("accept flag", 16'h0000, {15'h0, cmd_reject_out});
  endtask

  task automatic t_echo();
    logic [15:0] tx;
    tx = 16'hf0ff;
    frame(16'ha0ff);
    frame(tx);
    cmp("echo", {1'b0, tx[15:1]}, rx);
    outs("echo frame", 16'h0131, 1'b0);
    frame(16'h0000);
    cmp("after echo", 16'h0000, rx);
  endtask

  task automatic t_sticky();
    frame(16'h0000);
    diag_in[1:0] = 2'h0;
    repeat (6) @(negedge clk_in);
    diag_in[1:0] = 2'h3;
    frame(16'h0000);
    cmp("sticky fault", {diag_in[15:2], 2'h0}, rx);
    // Settling pause a real master leaves before repeating a frame
    repeat (1500) @(negedge clk_in);
    frame(16'h0000);
    cmp("fault cleared", diag_in[15:0], rx);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    reset_n_in = 1'b0;
    par_in = 8'h00;
    diag_in = 32'h1be4_e41b;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_reset();
    t_or();
    t_diag();
    t_read();
    t_and();
    t_reject();
    t_echo();
    t_sticky();
    close_out();
  end
endmodule
